// ### design/rfoc_pkg.sv
// Package for the RF operation mode control register bank.
// Assumes a Wishbone classic slave with 32-bit data and byte addressing.
package rfoc_pkg;
  // ==========================================================
  // Register map
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  IDX_OP_CTRL     = 8'h02;
  localparam logic [7:0]  IDX_MODE_DEF    = 8'h03;
  localparam logic [7:0]  IDX_STATUS      = 8'h10;
  localparam logic [7:0]  IDX_EVENT       = 8'h11;
  localparam logic [7:0]  ADDR_OP_CTRL    = 8'h08;
  localparam logic [7:0]  ADDR_MODE_DEF   = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS     = 8'h40;
  localparam logic [7:0]  ADDR_EVENT      = 8'h44;
  // ==========================================================
  // Reset values and mode write mask
  localparam logic [7:0]  OP_CTRL_RST     = 8'h00;
  localparam logic [7:0]  MODE_DEF_RST    = 8'h08;
  localparam logic [7:0]  MODE_DEF_WMASK  = 8'hFC;
  // ==========================================================
  // Operation control fields
  localparam int          OC_ENABLE       = 7;
  localparam int          OC_RX_ON        = 6;
  localparam int          OC_SINGLE_CH    = 5;
  localparam int          OC_MANUAL_CH    = 4;
  localparam int          OC_TX_ON        = 3;
  localparam int          OC_WAKE         = 2;
  localparam int          OC_FD_HI        = 1;
  localparam int          OC_FD_LO        = 0;
  // ==========================================================
  // Mode definition fields
  localparam int          MD_TARGET       = 7;
  localparam int          MD_OPC_HI       = 6;
  localparam int          MD_OPC_LO       = 3;
  localparam int          MD_MOD_KIND     = 2;
  // ==========================================================
  // Codes
  localparam logic [1:0]  FD_OFF          = 2'h0;
  localparam logic [1:0]  FD_COLL_AVOID   = 2'h1;
  localparam logic [1:0]  FD_PEER         = 2'h2;
  localparam logic [1:0]  FD_AUTO         = 2'h3;
  localparam logic [3:0]  OPC_ISO_A       = 4'h1;
  localparam logic [3:0]  OPC_ISO_B       = 4'h2;
  localparam logic [3:0]  OPC_T1_TAG      = 4'h4;
  localparam logic [3:0]  OPC_SUBC_STREAM = 4'hE;
  localparam logic [3:0]  OPC_BPSK_STREAM = 4'hF;
  localparam logic [3:0]  OPC_TGT_ISO_A   = 4'h1;
  localparam logic [3:0]  OPC_TGT_NFC_F   = 4'h4;
  localparam int          BRD_FLAG        = 3;
  localparam int          BRD_NFC_F       = 2;
  localparam int          BRD_ISO_A       = 0;
  // ==========================================================
  // Decoded protocol modes
  typedef enum logic [3:0] {
    RFOC_PM_NONE,
    RFOC_PM_INIT_A,
    RFOC_PM_INIT_B,
    RFOC_PM_INIT_T1,
    RFOC_PM_INIT_SUBC,
    RFOC_PM_INIT_BPSK,
    RFOC_PM_TGT_A,
    RFOC_PM_TGT_F,
    RFOC_PM_TGT_BRD,
    RFOC_PM_TGT_BAD
  } rfoc_proto_t;
  // Channel usage
  typedef enum logic [1:0] {
    RFOC_CH_AUTO,
    RFOC_CH_BOTH_MANUAL,
    RFOC_CH_SINGLE
  } rfoc_chan_t;
endpackage

// ### design/rfoc_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes clk_i is the only clock; rst_i is synchronous active high.
`timescale 1ns/10ps
module rfoc_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_ff;
  logic nxt_meta;
  logic q_ff;
  logic nxt_q;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_meta = d_i;
    nxt_q    = meta_ff;
    if (rst_i) begin
      nxt_meta = 1'b0;
      nxt_q    = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    meta_ff <= nxt_meta;
    q_ff    <= nxt_q;
  end

  assign q_o = q_ff;
endmodule // rfoc_sync

// ### design/rfoc_top.sv
// Operation control and mode definition register bank, Wishbone classic slave.
// Assumes power-up reset on por_i, bus reset on rst_i, pin levels async.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
module rfoc_top
  import rfoc_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   por_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [rfoc_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   crystal_stable_i,
  input  wire logic                   channel_choice_i,
  input  wire logic                   field_on_cmd_i,
  input  wire logic                   tx_done_active_i,
  input  wire logic                   transport_frame_header_i,
  output logic                        osc_reg_en_o,
  output logic                        rx_en_o,
  output logic                        rx_am_en_o,
  output logic                        rx_pm_en_o,
  output logic                        rx_auto_sel_o,
  output logic                        tx_en_o,
  output logic                        wake_timer_mode_o,
  output logic                        fd_en_o,
  output logic                        fd_peer_thr_o,
  output logic                        fd_auto_o,
  output logic                        low_power_nfc_o,
  output logic                        listener_role_o,
  output logic      [3:0]             operation_code_o,
  output rfoc_pkg::rfoc_proto_t       proto_mode_o,
  output logic                        brd_nfc_f_o,
  output logic                        brd_iso_a_o,
  output logic                        modulation_kind_o
);
  import rfoc_pkg::*;
  // ==========================================================
  // Pin synchronisers
  logic xtal_ok;
  logic chan_sel;
  rfoc_sync u_sync_xtal (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (crystal_stable_i),
    .q_o   (xtal_ok)
  );
  rfoc_sync u_sync_chan (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (channel_choice_i),
    .q_o   (chan_sel)
  );
  // ==========================================================
  // Bus decode
  logic       req;
  logic       wr_lane0;
  logic       hit_op;
  logic       hit_md;
  logic       hit_st;
  logic       hit_ev;
  logic [7:0] wbyte;
  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
  assign wbyte    = wb_dat_i[7:0];
  always_comb begin
    hit_op = 1'b0;
    hit_md = 1'b0;
    hit_st = 1'b0;
    hit_ev = 1'b0;
    if (wb_adr_i == ADDR_OP_CTRL) begin
      hit_op = 1'b1;
    end else if (wb_adr_i == ADDR_MODE_DEF) begin
      hit_md = 1'b1;
    end else if (wb_adr_i == ADDR_STATUS) begin
      hit_st = 1'b1;
    end else if (wb_adr_i == ADDR_EVENT) begin
      hit_ev = 1'b1;
    end
  end
  // ==========================================================
  // Operation control register, power-up defaults only
  logic [7:0] op_ff;
  logic [7:0] nxt_op;
  always_comb begin
    nxt_op = op_ff;
    if (wr_lane0 && hit_op) begin
      nxt_op = wbyte;
    end
    // Hardware events win over a software write in the same cycle
    if (field_on_cmd_i) begin
      nxt_op[OC_TX_ON] = 1'b1;
    end else if (tx_done_active_i) begin
      nxt_op[OC_TX_ON] = 1'b0;
    end
    if (por_i) begin
      nxt_op = OP_CTRL_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    op_ff <= nxt_op;
  end
  // ==========================================================
  // Mode definition register
  logic [7:0] md_ff;
  logic [7:0] nxt_md;
  logic       md_wr_lost_ff;
  logic       nxt_md_wr_lost;
  always_comb begin
    nxt_md         = md_ff;
    nxt_md_wr_lost = md_wr_lost_ff;
    if (wr_lane0 && hit_md) begin
      if (xtal_ok) begin
        nxt_md = wbyte & MODE_DEF_WMASK;
      end else begin
        nxt_md_wr_lost = 1'b1;
      end
    end
    if (wr_lane0 && hit_ev && wbyte[0]) begin
      nxt_md_wr_lost = 1'b0;
    end
    // The mode register has no power-up-only note, so the bus reset restores it too
    if (por_i || rst_i) begin
      nxt_md         = MODE_DEF_RST;
      nxt_md_wr_lost = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    md_ff         <= nxt_md;
    md_wr_lost_ff <= nxt_md_wr_lost;
  end
  // ==========================================================
  // Mode decode
  logic [3:0]  opc;
  logic        is_tgt;
  rfoc_proto_t proto;
  logic        opc_bad;
  rfoc_chan_t  chan;
  logic [1:0]  fd;
  assign opc    = md_ff[MD_OPC_HI:MD_OPC_LO];
  assign is_tgt = md_ff[MD_TARGET];
  assign fd     = op_ff[OC_FD_HI:OC_FD_LO];
  always_comb begin
    proto = RFOC_PM_NONE;
    if (!is_tgt) begin
      case (opc)
        OPC_ISO_A:       proto = RFOC_PM_INIT_A;
        OPC_ISO_B:       proto = RFOC_PM_INIT_B;
        OPC_T1_TAG:      proto = RFOC_PM_INIT_T1;
        OPC_SUBC_STREAM: proto = RFOC_PM_INIT_SUBC;
        OPC_BPSK_STREAM: proto = RFOC_PM_INIT_BPSK;
        default:         proto = RFOC_PM_NONE;
      endcase
    end else if (opc[BRD_FLAG]) begin
      proto = RFOC_PM_TGT_BRD;
    end else begin
      case (opc)
        OPC_TGT_ISO_A: proto = RFOC_PM_TGT_A;
        OPC_TGT_NFC_F: proto = RFOC_PM_TGT_F;
        default:       proto = RFOC_PM_TGT_BAD;
      endcase
    end
  end

  // Disallowed target codes are treated like unsupported initiator codes
  assign opc_bad = (proto == RFOC_PM_NONE) || (proto == RFOC_PM_TGT_BAD);

  always_comb begin
    if (op_ff[OC_SINGLE_CH]) begin
      chan = RFOC_CH_SINGLE;
    end else if (op_ff[OC_MANUAL_CH]) begin
      chan = RFOC_CH_BOTH_MANUAL;
    end else begin
      chan = RFOC_CH_AUTO;
    end
  end

  // ==========================================================
  // Registered control outputs
  logic        osc_ff,  nxt_osc;
  logic        rx_ff,   nxt_rx;
  logic        am_ff,   nxt_am;
  logic        pm_ff,   nxt_pm;
  logic        auto_ff, nxt_auto;
  logic        tx_ff,   nxt_tx;
  logic        wake_ff, nxt_wake;
  logic        fde_ff,  nxt_fde;
  logic        fdp_ff,  nxt_fdp;
  logic        fda_ff,  nxt_fda;
  logic        lp_ff,   nxt_lp;
  logic        role_ff, nxt_role;
  logic [3:0]  opc_ff,  nxt_opc;
  rfoc_proto_t pm_mode_ff, nxt_pm_mode;
  logic        brdf_ff, nxt_brdf;
  logic        brda_ff, nxt_brda;
  logic        mod_ff,  nxt_mod;
  logic        hdr_conflict_ff, nxt_hdr_conflict;
  always_comb begin
    nxt_osc  = op_ff[OC_ENABLE];
    nxt_rx   = op_ff[OC_RX_ON] && !opc_bad;
    nxt_am   = 1'b0;
    nxt_pm   = 1'b0;
    nxt_auto = 1'b0;
    if (nxt_rx) begin
      case (chan)
        RFOC_CH_SINGLE: begin
          nxt_am = !chan_sel;
          nxt_pm = chan_sel;
        end
        RFOC_CH_BOTH_MANUAL: begin
          nxt_am = !chan_sel;
          nxt_pm = chan_sel;
        end
        default: begin
          nxt_am   = 1'b1;
          nxt_pm   = 1'b1;
          nxt_auto = 1'b1;
        end
      endcase
    end
    nxt_tx      = op_ff[OC_TX_ON] && !opc_bad;
    nxt_wake    = op_ff[OC_WAKE];
    nxt_fde     = (fd != FD_OFF);
    nxt_fdp     = (fd == FD_PEER);
    nxt_fda     = (fd == FD_AUTO);
    nxt_lp      = (fd != FD_OFF) && (op_ff[OC_ENABLE:OC_WAKE] == 6'h00);
    nxt_role    = is_tgt;
    nxt_opc     = opc;
    nxt_pm_mode = proto;
    nxt_brdf    = (proto == RFOC_PM_TGT_BRD) && opc[BRD_NFC_F];
    nxt_brda    = (proto == RFOC_PM_TGT_BRD) && opc[BRD_ISO_A];
    nxt_mod     = md_ff[MD_MOD_KIND];
    // Flags software breaking the header rule; hardware does not override it
    nxt_hdr_conflict = (proto == RFOC_PM_TGT_BRD) && transport_frame_header_i;
  end

  always_ff @(posedge clk_i) begin
    osc_ff          <= nxt_osc;
    rx_ff           <= nxt_rx;
    am_ff           <= nxt_am;
    pm_ff           <= nxt_pm;
    auto_ff         <= nxt_auto;
    tx_ff           <= nxt_tx;
    wake_ff         <= nxt_wake;
    fde_ff          <= nxt_fde;
    fdp_ff          <= nxt_fdp;
    fda_ff          <= nxt_fda;
    lp_ff           <= nxt_lp;
    role_ff         <= nxt_role;
    opc_ff          <= nxt_opc;
    pm_mode_ff      <= nxt_pm_mode;
    brdf_ff         <= nxt_brdf;
    brda_ff         <= nxt_brda;
    mod_ff          <= nxt_mod;
    hdr_conflict_ff <= nxt_hdr_conflict;
  end
  // ==========================================================
  // Bus answer: one wait-free cycle, unmapped reads zero
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic        ack_ff;
  logic        nxt_ack;
  always_comb begin
    nxt_ack = req;
    nxt_dat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (hit_op) begin
        nxt_dat = {24'h00_0000, op_ff};
      end else if (hit_md) begin
        nxt_dat = {24'h00_0000, md_ff};
      end else if (hit_st) begin
        nxt_dat = {24'h00_0000, 2'h0, hdr_conflict_ff, lp_ff, opc_bad, chan_sel,
                   xtal_ok, rx_ff};
      end else if (hit_ev) begin
        nxt_dat = {31'h0000_0000, md_wr_lost_ff};
      end
    end
    if (rst_i) begin
      nxt_ack = 1'b0;
      nxt_dat = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    ack_ff <= nxt_ack;
    dat_ff <= nxt_dat;
  end
  assign wb_ack_o          = ack_ff;
  assign wb_dat_o          = dat_ff;
  assign osc_reg_en_o      = osc_ff;
  assign rx_en_o           = rx_ff;
  assign rx_am_en_o        = am_ff;
  assign rx_pm_en_o        = pm_ff;
  assign rx_auto_sel_o     = auto_ff;
  assign tx_en_o           = tx_ff;
  assign wake_timer_mode_o = wake_ff;
  assign fd_en_o           = fde_ff;
  assign fd_peer_thr_o     = fdp_ff;
  assign fd_auto_o         = fda_ff;
  assign low_power_nfc_o   = lp_ff;
  assign listener_role_o   = role_ff;
  assign operation_code_o  = opc_ff;
  assign proto_mode_o      = pm_mode_ff;
  assign brd_nfc_f_o       = brdf_ff;
  assign brd_iso_a_o       = brda_ff;
  assign modulation_kind_o = mod_ff;
endmodule // rfoc_top

// ### test/rfoc_top_monitor.sv
// Checker for the RF operation mode register bank.
// Assumes it is bound to rfoc_top and sees only that module's ports.
`timescale 1ns/10ps
module rfoc_top_monitor
  import rfoc_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  por_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [ADDR_W-1:0]     wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  osc_reg_en_o,
  input wire logic                  rx_en_o,
  input wire logic                  rx_am_en_o,
  input wire logic                  rx_pm_en_o,
  input wire logic                  rx_auto_sel_o,
  input wire logic                  tx_en_o,
  input wire logic                  wake_timer_mode_o,
  input wire logic                  fd_en_o,
  input wire logic                  fd_peer_thr_o,
  input wire logic                  fd_auto_o,
  input wire logic                  low_power_nfc_o,
  input wire logic                  listener_role_o,
  input wire logic [3:0]            operation_code_o,
  input wire rfoc_pkg::rfoc_proto_t proto_mode_o,
  input wire logic                  brd_nfc_f_o,
  input wire logic                  brd_iso_a_o
);
  import rfoc_pkg::*;
  // ==========================================================
  // Bus steps
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence wr_op_s; req_s ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_OP_CTRL); endsequence
  sequence rd_op_s; req_s ##0 (!wb_we_i && wb_adr_i == ADDR_OP_CTRL); endsequence
  sequence rd_md_s; req_s ##0 (!wb_we_i && wb_adr_i == ADDR_MODE_DEF); endsequence
  // ==========================================================
  // Properties
  ack_answer_a: assert property (req_s |=> wb_ack_o) else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  op_write_a: assert property (wr_op_s |-> ##2 (osc_reg_en_o == $past(wb_dat_i[7], 2) &&
    wake_timer_mode_o == $past(wb_dat_i[2], 2))) else $error("op write not applied");
  op_read_a: assert property (rd_op_s |=> wb_ack_o && wb_dat_o[7] == osc_reg_en_o &&
    wb_dat_o[2] == wake_timer_mode_o) else $error("op readback differs");
  mode_read_a: assert property (rd_md_s |=> wb_dat_o[1:0] == 2'h0 &&
    wb_dat_o[7:3] == {listener_role_o, operation_code_o}) else $error("mode readback differs");
  rx_off_a: assert property (!rx_en_o |-> !rx_am_en_o && !rx_pm_en_o)
    else $error("channel on with rx off");
  rx_auto_a: assert property (rx_en_o && rx_auto_sel_o |-> rx_am_en_o && rx_pm_en_o)
    else $error("auto mode lacks a channel");
  fd_code_a: assert property (fd_auto_o || fd_peer_thr_o |-> fd_en_o &&
    !(fd_auto_o && fd_peer_thr_o)) else $error("detector decode bad");
  low_power_a: assert property (low_power_nfc_o |-> fd_en_o && !osc_reg_en_o && !rx_en_o &&
    !tx_en_o && !wake_timer_mode_o) else $error("low power with other bits");
  bad_code_a: assert property (proto_mode_o inside {RFOC_PM_NONE, RFOC_PM_TGT_BAD}
    |-> !tx_en_o && !rx_en_o) else $error("tx or rx on with bad code");
  init_b_a: assert property (!listener_role_o && operation_code_o == OPC_ISO_B
    |-> proto_mode_o == RFOC_PM_INIT_B) else $error("initiator B decode bad");
  brd_mode_a: assert property (listener_role_o && operation_code_o[3] |->
    proto_mode_o == RFOC_PM_TGT_BRD && brd_nfc_f_o == operation_code_o[2] &&
    brd_iso_a_o == operation_code_o[0]) else $error("bit rate detect decode bad");
endmodule // rfoc_top_monitor

bind rfoc_top rfoc_top_monitor u_mon (.*);

// ### test/rf_operation_mode_control_test.sv
// Self-checking bench for the RF operation mode register bank.
// Assumes rfoc_top with its checker bound; the bench drives all input ports.
`timescale 1ns/10ps
module rf_operation_mode_control_test;
  import rfoc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic crystal_stable_i = 1'b0, channel_choice_i = 1'b0, field_on_cmd_i = 1'b0;
  logic tx_done_active_i = 1'b0, transport_frame_header_i = 1'b0;
  logic wb_ack_o, osc_reg_en_o, rx_en_o, rx_am_en_o, rx_pm_en_o, rx_auto_sel_o, tx_en_o;
  logic wake_timer_mode_o, fd_en_o, fd_peer_thr_o, fd_auto_o, low_power_nfc_o;
  logic listener_role_o, brd_nfc_f_o, brd_iso_a_o, modulation_kind_o;
  logic [3:0] operation_code_o;
  rfoc_proto_t proto_mode_o;
  int n_mismatch = 0, num_checks = 0;
  logic [7:0] rd;
  // ==========================================================
  // Expected tables
  logic [7:0] od [9] = '{8'hC0, 8'hE0, 8'hD0, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08};
  logic [9:0] oe [9] = '{10'h3C0, 10'h340, 10'h380, 10'h009, 10'h00D, 10'h00B, 10'h010,
                         10'h018, 10'h020};
  logic [7:0] md [13] = '{8'h08, 8'h10, 8'h20, 8'h70, 8'h78, 8'h00, 8'h18, 8'h88, 8'hA0,
                          8'hC8, 8'hE0, 8'h90, 8'h0F};
  // Proto field follows the enum order NONE..TGT_BAD as 0..9
  logic [9:0] me [13] = '{10'h070, 10'h0B0, 10'h0F0, 10'h130, 10'h170, 10'h000, 10'h000,
                          10'h1B2, 10'h1F2, 10'h236, 10'h23A, 10'h242, 10'h071};
  wire [9:0] op_v = {osc_reg_en_o, rx_en_o, rx_am_en_o, rx_pm_en_o, tx_en_o,
                     wake_timer_mode_o, fd_en_o, fd_peer_thr_o, fd_auto_o, low_power_nfc_o};
  wire [9:0] md_v = {proto_mode_o, tx_en_o, rx_en_o, brd_nfc_f_o, brd_iso_a_o,
                     listener_role_o, modulation_kind_o};

  rfoc_top DUT (.*);

  always #50 clk_i = ~clk_i;
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reads sample ack and data before the edge updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, exp);
  endtask
  task automatic pulse(input int sel);
    @(posedge clk_i);
    if (sel == 0) field_on_cmd_i <= 1'b1;
    else tx_done_active_i <= 1'b1;
    @(posedge clk_i);
    field_on_cmd_i <= 1'b0;
    tx_done_active_i <= 1'b0;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rchk("op reset", ADDR_OP_CTRL, 8'h00);
    rchk("mode reset", ADDR_MODE_DEF, 8'h08);
    chk("proto reset", proto_mode_o, RFOC_PM_INIT_A);
    chk("code reset", operation_code_o, 4'h1);
    wr(ADDR_MODE_DEF, 8'h10);
    rchk("mode refused", ADDR_MODE_DEF, 8'h08);
    rchk("write refused", ADDR_EVENT, 8'h01);
    wr(ADDR_EVENT, 8'h01);
    rchk("refusal cleared", ADDR_EVENT, 8'h00);
    crystal_stable_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      channel_choice_i <= (i == 1);
      wr(ADDR_OP_CTRL, od[i]);
      chk("op outputs", op_v, oe[i]);
      if (i < 3) chk("auto select", rx_auto_sel_o, i == 0);
    end
    pulse(1);
    rchk("tx cleared", ADDR_OP_CTRL, 8'h00);
    wr(ADDR_OP_CTRL, 8'h01);
    pulse(0);
    rchk("tx set", ADDR_OP_CTRL, 8'h09);
    chk("tx output", tx_en_o, 1'b1);
    wr(ADDR_OP_CTRL, 8'hCB);
    for (int i = 0; i < 13; i++) begin
      transport_frame_header_i <= !md[i][7];
      wr(ADDR_MODE_DEF, md[i]);
      chk("mode outputs", md_v, me[i]);
      rchk("mode read", ADDR_MODE_DEF, md[i] & 8'hFC);
      if (i == 0 || i == 9 || i == 11) begin
        rchk("status", ADDR_STATUS, (i == 11) ? 8'h0A : 8'h03);
      end
    end
    wr(ADDR_OP_CTRL, 8'h84);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("op kept", ADDR_OP_CTRL, 8'h84);
    rchk("mode after reset", ADDR_MODE_DEF, 8'h08);
    rchk("unmapped", 8'h20, 8'h00);
    finish_test();
  end
endmodule // rf_operation_mode_control_test
